//--- pkg/pd_status_pkg.sv
// Package for the PD status and interrupt register group.
// Assumes one core clock at 100 MHz and a synchronous active-high reset.
package pd_status_pkg;
  localparam logic [7:0] ADDR_TOGGLE_SOP   = 8'h3D;
  localparam logic [7:0] ADDR_EVENT_FLAGS  = 8'h3E;
  localparam logic [7:0] ADDR_ACK_FLAG     = 8'h3F;
  localparam logic [7:0] ADDR_CC_STATUS    = 8'h40;
  localparam logic [7:0] ADDR_EVENT_MASK   = 8'h0E;
  localparam logic [7:0] ADDR_POWER        = 8'h0B;
  localparam logic [7:0] ADDR_MEASURE      = 8'h02;

  localparam logic [7:0] RESET_VALUE       = 8'h00;
  localparam int         TOGGLE_LSB        = 3;
  localparam int         POWER_MEASURE_BIT = 2;
  localparam int         MEAS_LINE1_BIT    = 2;
  localparam int         MEAS_LINE2_BIT    = 3;
  localparam int         WAKE_ENABLE_BIT   = 0;

  localparam logic [2:0] TOG_RUNNING   = 3'h0;
  localparam logic [2:0] TOG_SRC_LINE1 = 3'h1;
  localparam logic [2:0] TOG_SRC_LINE2 = 3'h2;
  localparam logic [2:0] TOG_SNK_LINE1 = 3'h5;
  localparam logic [2:0] TOG_SNK_LINE2 = 3'h6;
  localparam logic [2:0] TOG_AUDIO     = 3'h7;

  localparam logic [1:0] LVL_BELOW_200 = 2'h0;
  localparam logic [1:0] LVL_TO_660    = 2'h1;
  localparam logic [1:0] LVL_TO_1230   = 2'h2;
  localparam logic [1:0] LVL_ABOVE     = 2'h3;
  localparam int         LEVEL1_MV     = 200;
  localparam int         LEVEL2_MV     = 660;
  localparam int         LEVEL3_MV     = 1230;

  localparam int         CLK_PERIOD_NS     = 10;
  localparam int         ACTIVITY_HOLD_NS  = 20000;
  localparam int         ACTIVITY_HOLD_CYC = ACTIVITY_HOLD_NS / CLK_PERIOD_NS;
  localparam int         ACTIVITY_MIN_EDGES = 3;

  typedef struct packed {
    logic overcurrent_or_heat;
    logic toggle_finished;
    logic soft_reset_failed;
    logic retransmit_failed;
    logic hard_reset_sent;
    logic packet_acked;
    logic soft_reset_received;
    logic hard_reset_received;
  } pd_events_t;

  typedef struct packed {
    logic       toggle_running;
    logic       settled_source_line1;
    logic       settled_source_line2;
    logic       settled_sink_line1;
    logic       settled_sink_line2;
    logic       audio_accessory;
    logic       rx_sop_valid;
    logic [1:0] rx_sop_kind;
  } toggle_sop_t;

  typedef struct packed {
    logic        bus_power_good;
    logic        comparator_high;
    logic        checksum_good_pulse;
    logic        checksum_bad_pulse;
    logic        tx_fifo_full;
    logic        rx_fifo_full;
    logic        attach_seen;
    logic [11:0] cc_millivolts;
  } cc_inputs_t;
endpackage

//--- rtl/event_flag_bank.sv
// Read-to-clear sticky flag bank.
// Assumes event pulses come from the core clock domain.
`timescale 1ns/1ps
module event_flag_bank #(
  parameter int WIDTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] event_pulse,
  input  wire logic             read_clear,
  output logic      [WIDTH-1:0] flags_reg
);
  // Set wins over a read in the same cycle so no event is lost
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      flags_reg <= '0;
    end else if (read_clear) begin
      flags_reg <= event_pulse;
    end else begin
      flags_reg <= flags_reg | event_pulse;
    end
  end
endmodule

//--- rtl/cc_activity_detect.sv
// Bus activity detector on the active CC line.
// Assumes cc_line_sync is already synchronised to core_clk.
`timescale 1ns/1ps
module cc_activity_detect #(
  parameter int HOLD_CYCLES = pd_status_pkg::ACTIVITY_HOLD_CYC,
  parameter int MIN_EDGES   = pd_status_pkg::ACTIVITY_MIN_EDGES
) (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic cc_line_sync,
  output logic      active_reg
);
  logic        last_reg;
  logic [1:0]  edge_cnt_reg;
  logic [15:0] hold_cnt_reg;
  logic        edge_seen;

  assign edge_seen = cc_line_sync ^ last_reg;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      last_reg <= 1'b0;
    end else begin
      last_reg <= cc_line_sync;
    end
  end

  // Edge count restarts when the line has been quiet for the hold time
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      edge_cnt_reg <= 2'h0;
      hold_cnt_reg <= 16'h0000;
      active_reg   <= 1'b0;
    end else if (edge_seen) begin
      hold_cnt_reg <= 16'(HOLD_CYCLES);
      if (edge_cnt_reg < 2'(MIN_EDGES - 1)) begin
        edge_cnt_reg <= edge_cnt_reg + 2'h1;
      end else begin
        active_reg <= 1'b1;
      end
    end else if (hold_cnt_reg != 16'h0000) begin
      hold_cnt_reg <= hold_cnt_reg - 16'h0001;
    end else begin
      edge_cnt_reg <= 2'h0;
      active_reg   <= 1'b0;
    end
  end
endmodule

//--- rtl/pd_status_regs.sv
// Status and interrupt registers of the Type-C port controller PD layer.
// Assumes register access over the I2C port's internal byte interface, same clock.
`timescale 1ns/1ps
module pd_status_regs (
  input  wire logic                       core_clk,
  input  wire logic                       sys_rst,
  input  wire logic                       reg_wr_en,
  input  wire logic                       reg_rd_en,
  input  wire logic [7:0]                 reg_addr,
  input  wire logic [7:0]                 reg_wr_data,
  output logic      [7:0]                 reg_rd_data,
  input  wire pd_status_pkg::pd_events_t  pd_events,
  input  wire logic                       ack_sent_pulse,
  input  wire pd_status_pkg::toggle_sop_t toggle_sop,
  input  wire pd_status_pkg::cc_inputs_t  cc_inputs,
  input  wire logic                       cc_line_pin,
  input  wire logic                       bus_power_pin,
  input  wire logic                       comparator_pin,
  output logic                            irq_n
);
  logic [1:0] cc_sync_reg;
  logic [1:0] vbus_sync_reg;
  logic [1:0] comp_sync_reg;
  logic [7:0] event_mask_reg;
  logic [7:0] power_reg;
  logic [7:0] measure_reg;
  logic [2:0] toggle_code_reg;
  logic [2:0] sop_flags_reg;
  logic       checksum_reg;
  logic       alert_reg;
  logic       wake_reg;
  logic [1:0] level_reg;
  logic       activity;
  logic [7:0] event_flags;
  logic [7:0] ack_flags;
  logic [7:0] rd_next;
  logic       rd_events;
  logic       rd_ack;
  logic       measure_on;

  // Two-flop synchronisers for pin-level inputs
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cc_sync_reg   <= 2'h0;
      vbus_sync_reg <= 2'h0;
      comp_sync_reg <= 2'h0;
    end else begin
      cc_sync_reg   <= {cc_sync_reg[0], cc_line_pin};
      vbus_sync_reg <= {vbus_sync_reg[0], bus_power_pin};
      comp_sync_reg <= {comp_sync_reg[0], comparator_pin};
    end
  end

  // Writable control copies: mask, power and measure select
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      event_mask_reg <= pd_status_pkg::RESET_VALUE;
      power_reg      <= pd_status_pkg::RESET_VALUE;
      measure_reg    <= pd_status_pkg::RESET_VALUE;
    end else if (reg_wr_en) begin
      // Status and flag addresses have no write path
      unique case (reg_addr)
        pd_status_pkg::ADDR_EVENT_MASK: event_mask_reg <= reg_wr_data;
        pd_status_pkg::ADDR_POWER:      power_reg      <= {4'h0, reg_wr_data[3:0]};
        pd_status_pkg::ADDR_MEASURE:    measure_reg    <= reg_wr_data;
        default: begin
        end
      endcase
    end
  end

  // Toggle outcome encoding
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      toggle_code_reg <= pd_status_pkg::TOG_RUNNING;
    end else if (toggle_sop.toggle_running) begin
      toggle_code_reg <= pd_status_pkg::TOG_RUNNING;
    end else if (toggle_sop.audio_accessory) begin
      toggle_code_reg <= pd_status_pkg::TOG_AUDIO;
    end else if (toggle_sop.settled_source_line1) begin
      toggle_code_reg <= pd_status_pkg::TOG_SRC_LINE1;
    end else if (toggle_sop.settled_source_line2) begin
      toggle_code_reg <= pd_status_pkg::TOG_SRC_LINE2;
    end else if (toggle_sop.settled_sink_line1) begin
      toggle_code_reg <= pd_status_pkg::TOG_SNK_LINE1;
    end else if (toggle_sop.settled_sink_line2) begin
      toggle_code_reg <= pd_status_pkg::TOG_SNK_LINE2;
    end
  end

  // Last received packet kind: 0 plain, 1 prime debug, 2 double prime debug
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sop_flags_reg <= 3'h0;
    end else if (toggle_sop.rx_sop_valid) begin
      unique case (toggle_sop.rx_sop_kind)
        2'h0:    sop_flags_reg <= 3'h1;
        2'h1:    sop_flags_reg <= 3'h2;
        2'h2:    sop_flags_reg <= 3'h4;
        default: sop_flags_reg <= 3'h0;
      endcase
    end
  end

  // Checksum status: set on good, cleared on bad; good wins if both arrive
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      checksum_reg <= 1'b0;
    end else if (cc_inputs.checksum_good_pulse) begin
      checksum_reg <= 1'b1;
    end else if (cc_inputs.checksum_bad_pulse) begin
      checksum_reg <= 1'b0;
    end
  end

  assign measure_on = power_reg[pd_status_pkg::POWER_MEASURE_BIT] &&
                      (measure_reg[pd_status_pkg::MEAS_LINE1_BIT] ||
                       measure_reg[pd_status_pkg::MEAS_LINE2_BIT]);

  // Live CC status; level frozen while measure block is off
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      alert_reg <= 1'b0;
      wake_reg  <= 1'b0;
      level_reg <= pd_status_pkg::LVL_BELOW_200;
    end else begin
      alert_reg <= cc_inputs.tx_fifo_full | cc_inputs.rx_fifo_full;
      wake_reg  <= cc_inputs.attach_seen &
                   power_reg[pd_status_pkg::WAKE_ENABLE_BIT];
      if (measure_on) begin
        if (cc_inputs.cc_millivolts > 12'(pd_status_pkg::LEVEL3_MV)) begin
          level_reg <= pd_status_pkg::LVL_ABOVE;
        end else if (cc_inputs.cc_millivolts > 12'(pd_status_pkg::LEVEL2_MV)) begin
          level_reg <= pd_status_pkg::LVL_TO_1230;
        end else if (cc_inputs.cc_millivolts > 12'(pd_status_pkg::LEVEL1_MV)) begin
          level_reg <= pd_status_pkg::LVL_TO_660;
        end else begin
          level_reg <= pd_status_pkg::LVL_BELOW_200;
        end
      end
    end
  end

  cc_activity_detect u_activity (
    .core_clk     (core_clk),
    .sys_rst      (sys_rst),
    .cc_line_sync (cc_sync_reg[1]),
    .active_reg   (activity)
  );

  assign rd_events = reg_rd_en && (reg_addr == pd_status_pkg::ADDR_EVENT_FLAGS);
  assign rd_ack    = reg_rd_en && (reg_addr == pd_status_pkg::ADDR_ACK_FLAG);

  // Bit order matches flag positions 7 down to 0
  event_flag_bank #(.WIDTH(8)) u_events (
    .core_clk    (core_clk),
    .sys_rst     (sys_rst),
    .event_pulse (pd_events),
    .read_clear  (rd_events),
    .flags_reg   (event_flags)
  );

  event_flag_bank #(.WIDTH(8)) u_ack (
    .core_clk    (core_clk),
    .sys_rst     (sys_rst),
    .event_pulse ({7'h00, ack_sent_pulse}),
    .read_clear  (rd_ack),
    .flags_reg   (ack_flags)
  );

  always_comb begin
    rd_next = 8'h00;
    unique case (reg_addr)
      pd_status_pkg::ADDR_TOGGLE_SOP:
        rd_next = {2'h0, toggle_code_reg, sop_flags_reg};
      pd_status_pkg::ADDR_EVENT_FLAGS: rd_next = event_flags;
      pd_status_pkg::ADDR_ACK_FLAG:    rd_next = {7'h00, ack_flags[0]};
      pd_status_pkg::ADDR_CC_STATUS:
        rd_next = {vbus_sync_reg[1], activity, comp_sync_reg[1], checksum_reg,
                   alert_reg, wake_reg, level_reg};
      pd_status_pkg::ADDR_EVENT_MASK:  rd_next = event_mask_reg;
      pd_status_pkg::ADDR_POWER:       rd_next = power_reg;
      pd_status_pkg::ADDR_MEASURE:     rd_next = measure_reg;
      default:                         rd_next = 8'h00;
    endcase
  end

  // Read data registered; flags clear in the same edge
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rd_data <= 8'h00;
    end else if (reg_rd_en) begin
      reg_rd_data <= rd_next;
    end
  end

  // Second flag register has no mask, so it always drives the line
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= ~(|(event_flags & ~event_mask_reg) | ack_flags[0]);
    end
  end
endmodule

//--- bench/pd_host_model.sv
// Host side of the register port: byte reads and writes.
// Assumes one-cycle strobes taken at the rising edge of core_clk.
`timescale 1ns/1ps
module pd_host_model (
  input  wire logic       core_clk,
  output logic            reg_wr_en,
  output logic            reg_rd_en,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wr_data
);
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wr_data = 8'h00;
  end

  // Strobe lasts one edge; the next call waits an edge, so no back to back
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr_en <= wr;
    reg_rd_en <= !wr;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge core_clk);
    reg_wr_en <= 1'b0;
    reg_rd_en <= 1'b0;
  endtask
endmodule

//--- bench/pd_status_regs_checker.sv
// Port checks for the status and interrupt registers.
// Assumes mask writes at 0x0E are the only mask source.
`timescale 1ns/1ps
module pd_status_regs_checker (
  input wire logic                       core_clk,
  input wire logic                       sys_rst,
  input wire logic                       reg_wr_en,
  input wire logic                       reg_rd_en,
  input wire logic [7:0]                 reg_addr,
  input wire logic [7:0]                 reg_wr_data,
  input wire logic [7:0]                 reg_rd_data,
  input wire pd_status_pkg::pd_events_t  pd_events,
  input wire logic                       ack_sent_pulse,
  input wire pd_status_pkg::toggle_sop_t toggle_sop,
  input wire pd_status_pkg::cc_inputs_t  cc_inputs,
  input wire logic                       irq_n
);
  logic [7:0] mask_reg;
  wire        r3e = reg_rd_en && reg_addr == 8'h3E;

  always_ff @(posedge core_clk) begin
    if (sys_rst)
      mask_reg <= 8'h00;
    else if (reg_wr_en && reg_addr == 8'h0E)
      mask_reg <= reg_wr_data;
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  property p_irq_low;
    |(pd_events & ~mask_reg) |-> ##2 !irq_n;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("irq_n not low after event");
  property p_ack_irq;
    ack_sent_pulse |-> ##2 !irq_n;
  endproperty
  a_ack_irq: assert property (p_ack_irq) else $error("irq_n not low after ack");
  property p_rd_clear;
    (r3e && pd_events == 8'h00) ##1 pd_events == 8'h00 ##1 (r3e && pd_events == 8'h00)
      |=> reg_rd_data == 8'h00;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("flags survived read");
  property p_irq_rel;
    $rose(irq_n) |-> $past(reg_rd_en, 2) || $past(reg_wr_en, 2);
  endproperty
  a_irq_rel: assert property (p_irq_rel) else $error("irq_n rose unprompted");
  property p_unmapped;
    reg_rd_en && !(reg_addr inside {8'h02, 8'h0B, 8'h0E, [8'h3D:8'h40]})
      |=> reg_rd_data == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_audio;
    toggle_sop.audio_accessory [*2] ##0 (reg_rd_en && reg_addr == 8'h3D)
      |=> reg_rd_data[5:3] == 3'h7;
  endproperty
  a_audio: assert property (p_audio) else $error("audio code wrong");
  property p_alert;
    (cc_inputs.tx_fifo_full || cc_inputs.rx_fifo_full) [*2] ##0
      (reg_rd_en && reg_addr == 8'h40) |=> reg_rd_data[3];
  endproperty
  a_alert: assert property (p_alert) else $error("alert bit low");
  property p_tog_res;
    reg_rd_en && reg_addr == 8'h3D |=> reg_rd_data[7:6] == 2'h0;
  endproperty
  a_tog_res: assert property (p_tog_res) else $error("reserved bits set");
endmodule

bind pd_status_regs pd_status_regs_checker pd_status_regs_checker_i (.*);

//--- bench/tb_pd_status_regs.sv
// Self-checking bench for the status and interrupt registers.
// Assumes the host model drives the register port.
`timescale 1ns/1ps
module tb_pd_status_regs;
  logic                       core_clk;
  logic                       sys_rst;
  logic                       reg_wr_en;
  logic                       reg_rd_en;
  logic [7:0]                 reg_addr;
  logic [7:0]                 reg_wr_data;
  logic [7:0]                 reg_rd_data;
  pd_status_pkg::pd_events_t  pd_events;
  logic                       ack_sent_pulse;
  pd_status_pkg::toggle_sop_t toggle_sop;
  pd_status_pkg::cc_inputs_t  cc_inputs;
  logic                       cc_line_pin;
  logic                       bus_power_pin;
  logic                       comparator_pin;
  logic                       irq_n;
  logic [7:0]                 exp_q[$];
  logic [8:0]                 lv;
  int                         miscompares;
  int                         cmp_count;
  int                         cycles;
  integer                     seed;
  int                         lo[4] = '{0, 201, 661, 1231};
  int                         span[4] = '{199, 458, 568, 2864};
  logic [2:0]                 codes[6] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
  logic [7:0]                 addrs[5] = '{8'h3D, 8'h3E, 8'h3F, 8'h40, 8'h55};

  pd_status_regs pd_status_regs_i (.*);
  pd_host_model pd_host_model_i (.*);

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("compared %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    pd_host_model_i.xfer(1'b0, a, 8'h00);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    pd_host_model_i.xfer(1'b1, a, d);
  endtask

  // Read data lands on the read edge; look once it has settled
  always @(posedge core_clk) begin
    if (reg_rd_en) begin
      #1;
      check(reg_rd_data, exp_q.pop_front());
    end
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      results();
    end
  end

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    seed = 32'hC73A;
    miscompares = 0;
    cmp_count = 0;
    cycles = 0;
    sys_rst = 1'b1;
    pd_events = '0;
    ack_sent_pulse = 1'b0;
    toggle_sop = '0;
    cc_inputs = '0;
    cc_line_pin = 1'b0;
    bus_power_pin = 1'b0;
    comparator_pin = 1'b0;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    foreach (addrs[i]) begin
      wr(addrs[i], 8'($random(seed)));
      rd(addrs[i], 8'h00);
    end
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      pd_events <= 8'h01 << i;
      @(posedge core_clk);
      pd_events <= 8'h00;
      rd(8'h3E, 8'h01 << i);
      rd(8'h3E, 8'h00);
    end
    @(posedge core_clk);
    ack_sent_pulse <= 1'b1;
    @(posedge core_clk);
    ack_sent_pulse <= 1'b0;
    rd(8'h3F, 8'h01);
    rd(8'h3F, 8'h00);
    wr(8'h0E, 8'h40);
    @(posedge core_clk);
    pd_events <= 8'h40;
    @(posedge core_clk);
    pd_events <= 8'h00;
    repeat (3) @(posedge core_clk);
    #1;
    check({7'h00, irq_n}, 8'h01);
    rd(8'h3E, 8'h40);
    wr(8'h0E, 8'h00);
    for (int k = 0; k < 6; k++) begin
      lv = (9'h100 >> k) | ((k == 5) ? 9'h080 : 9'h000);
      @(posedge core_clk);
      toggle_sop <= lv | 9'h004 | 9'(k % 3);
      @(posedge core_clk);
      toggle_sop <= lv;
      rd(8'h3D, {2'h0, codes[k], 3'h1 << (k % 3)});
    end
    @(posedge core_clk);
    bus_power_pin <= 1'b1;
    comparator_pin <= 1'b1;
    cc_inputs.tx_fifo_full <= 1'b1;
    cc_inputs.checksum_good_pulse <= 1'b1;
    @(posedge core_clk);
    cc_inputs.checksum_good_pulse <= 1'b0;
    repeat (3) @(posedge core_clk);
    rd(8'h40, 8'hB8);
    comparator_pin <= 1'b0;
    cc_inputs.tx_fifo_full <= 1'b0;
    cc_inputs.rx_fifo_full <= 1'b1;
    cc_inputs.checksum_bad_pulse <= 1'b1;
    cc_inputs.attach_seen <= 1'b1;
    @(posedge core_clk);
    cc_inputs.checksum_bad_pulse <= 1'b0;
    repeat (3) @(posedge core_clk);
    rd(8'h40, 8'h88);
    cc_inputs.rx_fifo_full <= 1'b0;
    wr(8'h0B, 8'h05);
    wr(8'h02, 8'h04);
    // Line held quiet while the level is sampled
    for (int v = 0; v < 4; v++) begin
      cc_inputs.cc_millivolts <= 12'(lo[v] + $unsigned($random(seed)) % span[v]);
      repeat (2) @(posedge core_clk);
      rd(8'h40, 8'h84 | 8'(v));
    end
    repeat (2) begin
      @(posedge core_clk);
      cc_line_pin <= ~cc_line_pin;
      repeat (3) @(posedge core_clk);
    end
    repeat (4) @(posedge core_clk);
    rd(8'h40, 8'h87);
    cc_line_pin <= ~cc_line_pin;
    repeat (6) @(posedge core_clk);
    rd(8'h40, 8'hC7);
    repeat (1900) @(posedge core_clk);
    rd(8'h40, 8'hC7);
    repeat (150) @(posedge core_clk);
    rd(8'h40, 8'h87);
    repeat (3) @(posedge core_clk);
    results();
  end
endmodule
